// ===== rtl/fcs_sequencer.sv
// device-side sequencer watching a clock frequency change and dll relock
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"

// What this block does
// - clock free after entry hold; stable before exit
// - termination stays off unless disabled before entry: hold to relock for power-down, relock only for self refresh
// - ready at new frequency after lock time
// - mode sets spaced by four real edges
// - nanoseconds become cycles, rounded up
// - control bit a0 set turns dll off
module fcs_sequencer (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             cke,
  input  wire logic             termination_control,
  input  wire fcs_pkg::fcs_cmd_s cmd,
  input  wire logic             rtt_nom_en,
  input  wire logic             freq_change,
  input  wire logic             err_clear,
  output fcs_pkg::fcs_status_s  status,
  output fcs_pkg::fcs_err_s     err
);

  fcs_pkg::fcs_state_e  state_reg;
  fcs_pkg::fcs_state_e  state_next;
  logic                 sr_mode_reg;
  logic                 sr_mode_next;
  logic                 rtt_held_reg;
  logic                 rtt_held_next;
  logic                 dll_on_reg;
  logic                 dll_on_next;
  logic                 locked_reg;
  logic                 locked_next;
  fcs_pkg::fcs_err_s    err_reg;
  fcs_pkg::fcs_err_s    err_next;
  fcs_pkg::fcs_err_s    err_set;
  fcs_pkg::fcs_status_s status_reg;
  fcs_pkg::fcs_status_s status_next;

  logic                  phase_load;
  logic [`FCS_TMR_W-1:0] phase_val;
  logic                  phase_done;
  logic                  stable_load;
  logic                  stable_done;
  logic                  space_load;
  logic                  space_done;
  logic                  lock_load;
  logic                  lock_done;

  logic is_ms;
  logic ms_ok;
  logic ms_ok_state;
  logic enter_sleep;

  ////////////////////////////////////////////////////////////////////////
  // timers

  fcs_timer u_phase (
    .clk      (clk),
    .nrst     (nrst),
    .load     (phase_load),
    .load_val (phase_val),
    .done     (phase_done)
  );

  fcs_timer u_stable (
    .clk      (clk),
    .nrst     (nrst),
    .load     (stable_load),
    .load_val (`FCS_TMR_W'(`FCS_CKSRX_CYC - 1)),
    .done     (stable_done)
  );

  fcs_timer u_space (
    .clk      (clk),
    .nrst     (nrst),
    .load     (space_load),
    .load_val (`FCS_TMR_W'(`FCS_MRD_CYC - 1)),
    .done     (space_done)
  );

  fcs_timer u_lock (
    .clk      (clk),
    .nrst     (nrst),
    .load     (lock_load),
    .load_val (`FCS_TMR_W'(`FCS_DLLK_CYC - 1)),
    .done     (lock_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // command decode

  assign is_ms       = cmd.valid && (cmd.code == fcs_pkg::FCS_CMD_MODE_SET);
  assign ms_ok_state = (state_reg == fcs_pkg::FCS_ST_ACTIVE) || (state_reg == fcs_pkg::FCS_ST_MRS) ||
                       (state_reg == fcs_pkg::FCS_ST_RELOCK);
  // early mode sets are flagged and dropped so the spacing timer is not rearmed
  assign ms_ok       = is_ms && ms_ok_state && space_done;
  assign enter_sleep = cmd.valid && !cke && ((cmd.code == fcs_pkg::FCS_CMD_SR_ENTER) ||
                       (cmd.code == fcs_pkg::FCS_CMD_PD_ENTER));

  ////////////////////////////////////////////////////////////////////////
  // sequence

  always_comb begin
    state_next    = state_reg;
    sr_mode_next  = sr_mode_reg;
    rtt_held_next = rtt_held_reg;
    dll_on_next   = dll_on_reg;
    locked_next   = locked_reg;
    err_set       = '0;
    phase_load    = 1'b0;
    phase_val     = `FCS_TMR_W'(`FCS_CKSRE_CYC - 1);
    stable_load   = freq_change;
    space_load    = ms_ok;
    lock_load     = 1'b0;

    if (is_ms && !ms_ok) begin
      err_set.timing = 1'b1;
    end
    if (ms_ok && (cmd.mr_sel == `FCS_MR_DLL_CTRL)) begin
      dll_on_next = !cmd.a0;
    end
    if (freq_change) begin
      locked_next = 1'b0;
    end

    unique case (state_reg)
      fcs_pkg::FCS_ST_ACTIVE: begin
        if (freq_change) begin
          err_set.freq = 1'b1;
        end
        if (enter_sleep) begin
          state_next    = fcs_pkg::FCS_ST_HOLD;
          sr_mode_next  = (cmd.code == fcs_pkg::FCS_CMD_SR_ENTER);
          rtt_held_next = rtt_nom_en;
          phase_load    = 1'b1;
        end
      end
      fcs_pkg::FCS_ST_HOLD: begin
        // clock must still be valid until the entry hold has run out
        if (freq_change) begin
          err_set.freq = 1'b1;
        end
        if (cke) begin
          err_set.cke = 1'b1;
        end
        if (phase_done) begin
          state_next = fcs_pkg::FCS_ST_FREE;
        end
      end
      fcs_pkg::FCS_ST_FREE: begin
        // exit taken on enable high; same path for slow and fast exit
        if (cke) begin
          if (!stable_done || freq_change) begin
            err_set.early_exit = 1'b1;
          end
          state_next = fcs_pkg::FCS_ST_EXIT;
          phase_load = 1'b1;
          phase_val  = sr_mode_reg ? `FCS_TMR_W'(`FCS_TXS_CYC - 1) : `FCS_TMR_W'(`FCS_TXP_CYC - 1);
        end
      end
      fcs_pkg::FCS_ST_EXIT: begin
        if (freq_change) begin
          err_set.freq = 1'b1;
        end
        if (is_ms) begin
          err_set.timing = 1'b1;
        end
        if (!cke) begin
          err_set.cke = 1'b1;
        end
        if (phase_done) begin
          state_next = fcs_pkg::FCS_ST_MRS;
        end
      end
      fcs_pkg::FCS_ST_MRS: begin
        if (freq_change) begin
          err_set.freq = 1'b1;
        end
        if (!cke) begin
          err_set.cke = 1'b1;
        end
        if (ms_ok && (cmd.mr_sel == `FCS_MR_DLL_RESET) && cmd.a8) begin
          state_next = fcs_pkg::FCS_ST_RELOCK;
          lock_load  = 1'b1;
        end
      end
      fcs_pkg::FCS_ST_RELOCK: begin
        if (freq_change) begin
          err_set.freq = 1'b1;
        end
        if (!cke) begin
          err_set.cke = 1'b1;
        end
        if (termination_control && rtt_held_reg) begin
          err_set.term = 1'b1;
        end
        if (lock_done && !lock_load) begin
          state_next  = fcs_pkg::FCS_ST_ACTIVE;
          locked_next = 1'b1;
        end
      end
    endcase

    // a reset mode set outside the change path still restarts the lock
    if (ms_ok && (state_reg == fcs_pkg::FCS_ST_ACTIVE) && (cmd.mr_sel == `FCS_MR_DLL_RESET) && cmd.a8) begin
      state_next  = fcs_pkg::FCS_ST_RELOCK;
      lock_load   = 1'b1;
      locked_next = 1'b0;
    end
    if ((state_reg != fcs_pkg::FCS_ST_ACTIVE) && (state_reg != fcs_pkg::FCS_ST_RELOCK) &&
        !sr_mode_reg && termination_control && rtt_held_reg) begin
      err_set.term = 1'b1;
    end

    // a new event wins over a clear in the same cycle
    err_next = err_clear ? err_set : (err_reg | err_set);

    status_next.clock_free  = (state_next == fcs_pkg::FCS_ST_FREE);
    // termination is only live in normal operation, never while asleep
    status_next.term_active = (state_next == fcs_pkg::FCS_ST_ACTIVE) && termination_control && rtt_nom_en;
    status_next.dll_on      = dll_on_next;
    status_next.dll_locked  = locked_next;
    status_next.ready       = (state_next == fcs_pkg::FCS_ST_ACTIVE) && (locked_next || !dll_on_next);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= fcs_pkg::FCS_ST_ACTIVE;
      sr_mode_reg  <= 1'b0;
      rtt_held_reg <= 1'b0;
      dll_on_reg   <= 1'b1;
      locked_reg   <= 1'b0;
      err_reg      <= '0;
      status_reg   <= '0;
    end else begin
      state_reg    <= state_next;
      sr_mode_reg  <= sr_mode_next;
      rtt_held_reg <= rtt_held_next;
      dll_on_reg   <= dll_on_next;
      locked_reg   <= locked_next;
      err_reg      <= err_next;
      status_reg   <= status_next;
    end
  end

  assign status = status_reg;
  assign err    = err_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_exit_wait;
    (state_reg == fcs_pkg::FCS_ST_EXIT) [*3] ##1 (state_reg == fcs_pkg::FCS_ST_MRS);
  endsequence

  sequence s_spacing;
    !space_done [*3] ##1 space_done;
  endsequence

  a_hold_to_free: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == fcs_pkg::FCS_ST_HOLD) && phase_done |=> (state_reg == fcs_pkg::FCS_ST_FREE) ##0 status.clock_free)
    else $error("entry hold did not release the clock");

  a_entry_hold: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == fcs_pkg::FCS_ST_ACTIVE) && enter_sleep |=> (state_reg == fcs_pkg::FCS_ST_HOLD) ##1
    (state_reg == fcs_pkg::FCS_ST_FREE))
    else $error("entry hold length wrong");

  a_free_no_term: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg != fcs_pkg::FCS_ST_ACTIVE) |-> !status.term_active)
    else $error("termination active outside normal operation");

  a_mrs_spacing: assert property (@(posedge clk) disable iff (!nrst)
    ms_ok |=> s_spacing)
    else $error("mode set spacing not four edges");

  a_early_mrs: assert property (@(posedge clk) disable iff (!nrst)
    is_ms && !space_done |=> err.timing)
    else $error("early mode set not flagged");

  a_sr_exit_wait: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == fcs_pkg::FCS_ST_FREE) && cke && sr_mode_reg |=> s_exit_wait)
    else $error("self refresh exit wait not three cycles");

  // with the loop off no lock is needed, so normal operation is ready at once
  a_dll_off: assert property (@(posedge clk) disable iff (!nrst)
    ms_ok && (cmd.mr_sel == `FCS_MR_DLL_CTRL) && cmd.a0 |=>
    !status.dll_on && (status.ready == (state_reg == fcs_pkg::FCS_ST_ACTIVE)))
    else $error("dll not turned off");

  a_ready_lock: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == fcs_pkg::FCS_ST_MRS) ##1 (state_reg == fcs_pkg::FCS_ST_RELOCK) |->
    !status.ready ##[1:520] status.ready)
    else $error("not ready within lock time");

  a_freq_flag: assert property (@(posedge clk) disable iff (!nrst)
    freq_change && (state_reg == fcs_pkg::FCS_ST_ACTIVE) |=> err.freq && !status.dll_locked)
    else $error("illegal frequency change not flagged");

endmodule : fcs_sequencer
`default_nettype wire

// ===== include/fcs_defines.svh
// timing counts and field positions for the clock frequency change sequencer
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

`define FCS_CLK_PERIOD_NS  100
// nanosecond figures are plain defaults, converted by rounding up
`define FCS_CKSRE_NS       10
`define FCS_CKSRX_NS       10
`define FCS_TXP_NS         24
`define FCS_TXS_NS         270
`define FCS_NS_TO_CYC(ns)  ((((ns) + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS) < 1 ? 1 : \
                            (((ns) + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS))
`define FCS_CKSRE_CYC      `FCS_NS_TO_CYC(`FCS_CKSRE_NS)
`define FCS_CKSRX_CYC      `FCS_NS_TO_CYC(`FCS_CKSRX_NS)
`define FCS_TXP_CYC        `FCS_NS_TO_CYC(`FCS_TXP_NS)
`define FCS_TXS_CYC        `FCS_NS_TO_CYC(`FCS_TXS_NS)
`define FCS_MRD_CYC        4
`define FCS_DLLK_CYC       512

`define FCS_TMR_W          10
`define FCS_MR_DLL_RESET   2'h0
`define FCS_MR_DLL_CTRL    2'h1

`endif

// ===== include/fcs_pkg.sv
// types shared by the clock frequency change sequencer
package fcs_pkg;

  typedef enum logic [2:0] {
    FCS_CMD_NOP      = 3'h0,
    FCS_CMD_SR_ENTER = 3'h1,
    FCS_CMD_SR_EXIT  = 3'h2,
    FCS_CMD_PD_ENTER = 3'h3,
    FCS_CMD_MODE_SET = 3'h4
  } fcs_cmd_e;

  typedef enum logic [5:0] {
    FCS_ST_ACTIVE = 6'h01,
    FCS_ST_HOLD   = 6'h02,
    FCS_ST_FREE   = 6'h04,
    FCS_ST_EXIT   = 6'h08,
    FCS_ST_MRS    = 6'h10,
    FCS_ST_RELOCK = 6'h20
  } fcs_state_e;

  typedef struct packed {
    logic     valid;
    fcs_cmd_e code;
    logic [1:0] mr_sel;
    logic     a0;
    logic     a8;
  } fcs_cmd_s;

  typedef struct packed {
    logic ready;
    logic dll_on;
    logic dll_locked;
    logic clock_free;
    logic term_active;
  } fcs_status_s;

  typedef struct packed {
    logic freq;
    logic term;
    logic cke;
    logic timing;
    logic early_exit;
  } fcs_err_s;

endpackage : fcs_pkg

// ===== rtl/fcs_timer.sv
// down counter: loaded with n-1, done at the n-th edge after the load
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"

module fcs_timer (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  load,
  input  wire logic [`FCS_TMR_W-1:0] load_val,
  output logic                       done
);

  logic [`FCS_TMR_W-1:0] count_reg;
  logic [`FCS_TMR_W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != '0) begin
      count_next = count_reg - `FCS_TMR_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);

endmodule : fcs_timer
`default_nettype wire

// ===== test/fcs_ctrl_model.sv
// controller-side model driving the sequencer's pins
`timescale 1ns/1ps
`default_nettype none
module fcs_ctrl_model (
  input  wire logic         clk,
  output fcs_pkg::fcs_cmd_s cmd,
  output logic              cke,
  output logic              termination_control,
  output logic              freq_change
);
  ////////////////////////////////////////////////////////////////
  task automatic idle();
    cmd         <= '0;
    cke         <= 1'h1;
    termination_control         <= 1'h0;
    freq_change <= 1'h0;
  endtask : idle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic pin(input logic c, input logic o);
    cke <= c;
    termination_control <= o;
    tick(1);
  endtask : pin
  task automatic send(input logic [2:0] code, input logic [1:0] sel, input logic a0, input logic a8);
    cmd <= {1'h1, code, sel, a0, a8};
    tick(1);
    cmd <= '0;
  endtask : send
  // enable goes low first so the entry command is already taken with it low
  task automatic sleep(input logic [2:0] code, input logic o);
    pin(1'h0, o);
    send(code, 2'h0, 1'h0, 1'h0);
    tick(3);
  endtask : sleep
  task automatic change(input int gap);
    freq_change <= 1'h1;
    tick(1);
    freq_change <= 1'h0;
    tick(gap);
  endtask : change
  task automatic wake(input int xw, input logic with_freq);
    cke         <= 1'h1;
    termination_control         <= 1'h0;
    freq_change <= with_freq;
    tick(1);
    freq_change <= 1'h0;
    tick(xw - 1);
  endtask : wake
  // dll on first, then dll reset one spacing later
  task automatic relock();
    send(fcs_pkg::FCS_CMD_MODE_SET, 2'h1, 1'h0, 1'h0);
    tick(3);
    send(fcs_pkg::FCS_CMD_MODE_SET, 2'h0, 1'h0, 1'h1);
  endtask : relock
endmodule : fcs_ctrl_model
`default_nettype wire

// ===== test/tb_fcs_sequencer.sv
// testbench for the clock frequency change sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_fcs_sequencer;
  logic                 clk;
  logic                 nrst;
  logic                 rtt_nom_en;
  logic                 err_clear;
  logic                 cke;
  logic                 termination_control;
  logic                 freq_change;
  fcs_pkg::fcs_cmd_s    cmd;
  fcs_pkg::fcs_status_s status;
  fcs_pkg::fcs_err_s    err;
  int                   n_errors;
  int                   num_checks;
  int                   i;
  fcs_ctrl_model fcs_ctrl_model_i (.clk(clk), .cmd(cmd), .cke(cke), .termination_control(termination_control), .freq_change(freq_change));
  fcs_sequencer fcs_sequencer_i (.clk(clk), .nrst(nrst), .cke(cke), .termination_control(termination_control), .cmd(cmd),
    .rtt_nom_en(rtt_nom_en), .freq_change(freq_change), .err_clear(err_clear), .status(status), .err(err));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // compares cost one cycle: sampled at the falling edge, resumed at the rising one
  task automatic chk_err(input fcs_pkg::fcs_err_s exp);
    @(negedge clk);
    num_checks++;
    if (err !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, err);
    end
    @(posedge clk);
  endtask : chk_err
  task automatic chk_bit(input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_bit
  function automatic fcs_pkg::fcs_err_s exp_err(input logic f, input logic t, input logic c,
                                                 input logic tm, input logic e);
    return {f, t, c, tm, e};
  endfunction : exp_err
  task automatic do_reset;
    fcs_ctrl_model_i.idle();
    nrst <= 1'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
  endtask : do_reset
  task automatic clr;
    err_clear <= 1'h1;
    @(posedge clk);
    err_clear <= 1'h0;
    chk_err(exp_err(1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
  endtask : clr
  // whole change: sleep, new clock, wake, dll on and reset, then wait for lock
  task automatic walk(input logic [2:0] code, input logic rtt, input logic o, input int xw);
    int cnt;
    rtt_nom_en <= rtt;
    fcs_ctrl_model_i.sleep(code, o);
    @(negedge clk);
    chk_bit(1'h1, status.clock_free);
    chk_bit(1'h0, status.term_active);
    @(posedge clk);
    fcs_ctrl_model_i.change(2);
    fcs_ctrl_model_i.wake(xw, 1'h0);
    fcs_ctrl_model_i.relock();
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (status.ready !== 1'h1 && cnt < 600);
    chk_bit(1'h1, cnt >= 508 && cnt <= 520);
    chk_bit(1'h1, status.dll_locked);
    @(posedge clk);
    chk_err(exp_err(1'h0, rtt & o, 1'h0, 1'h0, 1'h0));
  endtask : walk
  ////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'h0;
    rtt_nom_en = 1'h0;
    err_clear = 1'h0;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(32'h8A7EAE8B));
    do_reset;
    @(negedge clk);
    chk_bit(1'h0, status.ready);
    @(posedge clk);
    for (i = 0; i < 4; i++) begin
      rtt_nom_en <= 1'($urandom % 2);
      @(posedge clk);
      walk(($urandom % 2) ? fcs_pkg::FCS_CMD_SR_ENTER : fcs_pkg::FCS_CMD_PD_ENTER, rtt_nom_en,
           !rtt_nom_en && ($urandom % 2), 4 + int'($urandom % 4));
    end
    walk(fcs_pkg::FCS_CMD_PD_ENTER, 1'h1, 1'h1, 4);
    clr;
    // a clear landing with the event must lose to it
    fork
      fcs_ctrl_model_i.change(1);
      begin
        err_clear <= 1'($urandom % 2);
        @(posedge clk);
        err_clear <= 1'h0;
      end
    join
    chk_err(exp_err(1'h1, 1'h0, 1'h0, 1'h0, 1'h0));
    clr;
    fcs_ctrl_model_i.send(fcs_pkg::FCS_CMD_MODE_SET, 2'h2, 1'h0, 1'h0);
    fcs_ctrl_model_i.tick(2);
    fcs_ctrl_model_i.send(fcs_pkg::FCS_CMD_MODE_SET, 2'h2, 1'h0, 1'h0);
    chk_err(exp_err(1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
    clr;
    fcs_ctrl_model_i.send(fcs_pkg::FCS_CMD_MODE_SET, 2'h2, 1'h0, 1'h0);
    fcs_ctrl_model_i.tick(3);
    fcs_ctrl_model_i.send(fcs_pkg::FCS_CMD_MODE_SET, 2'h2, 1'h0, 1'h0);
    chk_err(exp_err(1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    // loop off: ready without a lock; back on: ready waits for a new lock
    fcs_ctrl_model_i.tick(2);
    fcs_ctrl_model_i.send(fcs_pkg::FCS_CMD_MODE_SET, 2'h1, 1'h1, 1'h0);
    @(negedge clk);
    chk_bit(1'h0, status.dll_on);
    chk_bit(1'h1, status.ready);
    @(posedge clk);
    fcs_ctrl_model_i.tick(2);
    fcs_ctrl_model_i.send(fcs_pkg::FCS_CMD_MODE_SET, 2'h1, 1'h0, 1'h0);
    rtt_nom_en <= 1'h1;
    fcs_ctrl_model_i.pin(1'h1, 1'h1);
    @(negedge clk);
    chk_bit(1'h1, status.dll_on);
    chk_bit(1'h0, status.ready);
    chk_bit(1'h1, status.term_active);
    @(posedge clk);
    fcs_ctrl_model_i.pin(1'h0, 1'h0);
    fcs_ctrl_model_i.send(fcs_pkg::FCS_CMD_PD_ENTER, 2'h0, 1'h0, 1'h0);
    fcs_ctrl_model_i.pin(1'h1, 1'h0);
    chk_err(exp_err(1'h0, 1'h0, 1'h1, 1'h0, 1'h0));
    do_reset;
    fcs_ctrl_model_i.sleep(fcs_pkg::FCS_CMD_PD_ENTER, 1'h0);
    fcs_ctrl_model_i.wake(4, 1'h1);
    chk_err(exp_err(1'h0, 1'h0, 1'h0, 1'h0, 1'h1));
    do_reset;
    fcs_ctrl_model_i.sleep(fcs_pkg::FCS_CMD_SR_ENTER, 1'h0);
    fcs_ctrl_model_i.change(2);
    fcs_ctrl_model_i.wake(4, 1'h0);
    fcs_ctrl_model_i.relock();
    fcs_ctrl_model_i.tick(20);
    fcs_ctrl_model_i.pin(1'h0, 1'h0);
    chk_err(exp_err(1'h0, 1'h0, 1'h1, 1'h0, 1'h0));
    give_verdict;
  end
  // about 2800 cycles expected; the limit leaves wide margin
  initial begin
    repeat (12000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
endmodule : tb_fcs_sequencer
`default_nettype wire
